// ==== rtl/vbm_pkg.sv ====
// constants for the viterbi sync and error rate monitor block
package vbm_pkg;
    // ------------------------------------------------------------
    // host register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PERIOD_LO = 8'h10;
    localparam logic [7:0] ADDR_PERIOD_MID = 8'h11;
    localparam logic [7:0] ADDR_PERIOD_HI = 8'h12;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_SYNC_LEN = 8'h15;
    localparam logic [7:0] ADDR_SYNC_THR = 8'h16;
    localparam logic [7:0] ADDR_PERIOD_ARM = 8'h18;
    localparam logic [7:0] ADDR_BER_LO = 8'h19;
    localparam logic [7:0] ADDR_BER_HI = 8'h1a;
    localparam logic [7:0] ADDR_STATUS = 8'h1b;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_FMT_OFFBIN = 0;
    localparam int CTRL_ENC_RST = 1;
    localparam int CTRL_DEC_RST = 2;
    localparam int CTRL_PERMUTE = 3;
    localparam int CTRL_NSTATE_LO = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SYNC_LEN_RESET = 8'hff;
    localparam logic [7:0] SYNC_THR_RESET = 8'h10;
    localparam logic [23:0] PERIOD_RESET = 24'hffff9c;
    // ------------------------------------------------------------
    // error rate counter constants
    // ------------------------------------------------------------
    localparam int PERIOD_W = 24;
    localparam int BER_W = 16;
    localparam logic [9:0] WORDS_PER_UNIT = 10'h3e8;
    localparam logic [2:0] ERR_PRESCALE_MAX = 3'h7;
    localparam logic [15:0] BER_START = 16'h0001;
    localparam logic [1:0] DONE_TICKS = 2'h2;
    // ------------------------------------------------------------
    // reset pulse and sync test timing
    // ------------------------------------------------------------
    localparam logic [1:0] RST_PULSE_CYCLES = 2'h2;
    localparam logic [5:0] SYNC_UNIT_TICKS = 6'h3f;
    localparam int WORD_W = 3;
    typedef enum logic [1:0] {
        SS_ZERO = 2'b00,
        SS_ONE = 2'b01,
        SS_TWO = 2'b10,
        SS_THREE = 2'b11
    } vbm_sync_state_t;
endpackage : vbm_pkg

// ==== rtl/vbm_reset_edge.sv ====
// edge triggered reset pulse generator for encoder or decoder
`timescale 1ns/10ps
`default_nettype none
module vbm_reset_edge (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_level,
    input wire logic ctrl_bit,
    output logic reset_pulse
);
    logic req_d_r;
    logic [1:0] cnt_r;
    wire logic req = pin_level | ctrl_bit;

    // ------------------------------------------------------------
    // rising edge starts a short pulse, holding does nothing
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_d_r <= 1'b0;
            cnt_r <= 2'h0;
            reset_pulse <= 1'b0;
        end else begin
            req_d_r <= req;
            if (req && !req_d_r) begin
                cnt_r <= vbm_pkg::RST_PULSE_CYCLES - 2'h1;
                reset_pulse <= 1'b1;
            end else if (cnt_r != 2'h0) begin
                cnt_r <= cnt_r - 2'h1;
                reset_pulse <= 1'b1;
            end else begin
                reset_pulse <= 1'b0;
            end
        end
    end
endmodule // vbm_reset_edge
`default_nettype wire

// ==== rtl/vbm_ber_counter.sv ====
// code word and error accumulators of the error rate monitor
`timescale 1ns/10ps
`default_nettype none
module vbm_ber_counter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic word_tick,
    input wire logic mismatch,
    input wire logic restart,
    input wire logic [23:0] period_value,
    output logic [15:0] result,
    output logic done
);
    logic [9:0] unit_cnt_r;
    logic [23:0] kilo_cnt_r;
    logic [2:0] pre_r;
    logic [15:0] acc_r;
    logic [1:0] done_cnt_r;
    wire logic unit_end = (unit_cnt_r == vbm_pkg::WORDS_PER_UNIT - 10'h1);
    wire logic [23:0] kilo_inc = kilo_cnt_r + 24'h1;
    wire logic window_end = word_tick && unit_end && (kilo_inc == 24'h0);

    // ------------------------------------------------------------
    // word counter: (2^24 minus period value) times 1000 words
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_cnt_r <= 10'h0;
            kilo_cnt_r <= vbm_pkg::PERIOD_RESET;
        end else if (restart || window_end) begin
            unit_cnt_r <= 10'h0;
            kilo_cnt_r <= period_value;
        end else if (word_tick) begin
            unit_cnt_r <= unit_end ? 10'h0 : unit_cnt_r + 10'h1;
            if (unit_end) begin
                kilo_cnt_r <= kilo_inc;
            end
        end
    end

    // ------------------------------------------------------------
    // error accumulator, one count per 8 errors, saturates at zero
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 3'h0;
            acc_r <= vbm_pkg::BER_START;
        end else if (restart || window_end) begin
            pre_r <= 3'h0;
            acc_r <= vbm_pkg::BER_START;
        end else if (word_tick && mismatch && acc_r != 16'h0) begin
            pre_r <= pre_r + 3'h1;
            if (pre_r == vbm_pkg::ERR_PRESCALE_MAX) begin
                acc_r <= acc_r + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // holding register and done strobe of two word ticks
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= 16'h0;
            done_cnt_r <= 2'h0;
            done <= 1'b0;
        end else if (window_end) begin
            // the closing word's error still belongs to this window
            result <= (mismatch && pre_r == vbm_pkg::ERR_PRESCALE_MAX && acc_r != 16'h0) ?
                acc_r + 16'h1 : acc_r;
            done_cnt_r <= vbm_pkg::DONE_TICKS;
            done <= 1'b1;
        end else begin
            if (word_tick && done_cnt_r != 2'h0) begin
                done_cnt_r <= done_cnt_r - 2'h1;
            end
            done <= (done_cnt_r != 2'h0) && !(word_tick && done_cnt_r == 2'h1);
        end
    end
endmodule // vbm_ber_counter
`default_nettype wire

// ==== rtl/vbm_monitor.sv ====
// sync loop, input formatting, resets and error rate monitor top
// Function
// - report pass or fail each test period
// - sync monitor always runs, no enable
// - step request advances sync offset state
// - step realigns timing or permutes data
// - monitor keeps testing after each step
// - states advance in turn and wrap
// - 3-bit input, sign-magnitude or offset-binary
// - pin and control bit reset identically
// - reset acts on rising edge only
// - reset clears sync, encoder state
// - count code words and mismatches
// - 24-bit period scaled by 1000
// - period takes effect on arm write
// - measurement runs while output clock toggles
// - clear errors per period, copy to holding
// - window done high two output clocks
// - result: 1 none, 0 overflow, errors/8+1
// - accumulator saturates at all zeros
// - measurement restarts, result overwritten
// - host programs test length and threshold
// - fail when normalizations exceed threshold
`timescale 1ns/10ps
`default_nettype none
module vbm_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    // host processor port
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // demodulator and decoder side pins
    input wire logic [2:0] code_word_in_0,
    input wire logic [2:0] code_word_in_1,
    input wire logic [2:0] code_word_in_2,
    input wire logic decoder_output_clock,
    input wire logic normalization_event,
    input wire logic reencode_mismatch,
    input wire logic sync_step_request,
    input wire logic encoder_reset_pin,
    input wire logic decoder_reset_pin,
    output logic [2:0] dec_word_0,
    output logic [2:0] dec_word_1,
    output logic [2:0] dec_word_2,
    output logic in_sync_flag,
    output logic sync_lost_flag,
    output logic error_window_done,
    output logic encoder_reset,
    output logic decoder_reset
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    logic [8:0] word_meta_r;
    logic [8:0] word_sync_r;
    logic [5:0] pin_meta_r;
    logic [5:0] pin_sync_r;
    logic clk_d_r;
    logic norm_d_r;
    logic step_d_r;
    logic [7:0] ctrl_r;
    logic [7:0] sync_len_r;
    logic [7:0] sync_thr_r;
    logic [23:0] period_stage_r;
    logic [23:0] period_active_r;
    logic arm_r;
    logic [5:0] unit_cnt_r;
    logic [7:0] len_cnt_r;
    logic [7:0] norm_cnt_r;
    logic [15:0] ber_result;
    logic ber_done;
    logic enc_pulse;
    logic dec_pulse;
    logic [2:0] c0;
    logic [2:0] c1;
    logic [2:0] c2;
    logic [2:0] c0_d1_r;
    logic [2:0] c0_d2_r;
    logic [2:0] c0_d3_r;
    logic [2:0] c0_sel;
    vbm_pkg::vbm_sync_state_t sync_state_r;
    vbm_pkg::vbm_sync_state_t sync_state_nxt;
    logic [1:0] last_state;
    wire logic word_tick = pin_sync_r[0] && !clk_d_r;
    wire logic norm_rise = pin_sync_r[1] && !norm_d_r;
    wire logic step_rise = pin_sync_r[3] && !step_d_r;
    wire logic mismatch = pin_sync_r[2];
    wire logic unit_end = (unit_cnt_r == vbm_pkg::SYNC_UNIT_TICKS);
    wire logic test_end = word_tick && unit_end && (len_cnt_r == sync_len_r);
    wire logic host_wr_arm = host_wr && (host_addr == vbm_pkg::ADDR_PERIOD_ARM);
    wire logic [7:0] norm_total = (norm_rise && norm_cnt_r != 8'hff) ?
        norm_cnt_r + 8'h1 : norm_cnt_r;

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // two flops on every demodulator and decoder side pin before use
    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            word_meta_r <= 9'h0;
            word_sync_r <= 9'h0;
            pin_meta_r <= 6'h0;
            pin_sync_r <= 6'h0;
        end else begin
            word_meta_r <= {code_word_in_2, code_word_in_1, code_word_in_0};
            word_sync_r <= word_meta_r;
            pin_meta_r <= {decoder_reset_pin, encoder_reset_pin, sync_step_request,
                reencode_mismatch, normalization_event, decoder_output_clock};
            pin_sync_r <= pin_meta_r;
        end
    end

    // edge detectors look only at the second stage
    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            clk_d_r <= 1'b0;
            norm_d_r <= 1'b0;
            step_d_r <= 1'b0;
        end else begin
            clk_d_r <= pin_sync_r[0];
            norm_d_r <= pin_sync_r[1];
            step_d_r <= pin_sync_r[3];
        end
    end

    // ------------------------------------------------------------
    // host register writes
    // ------------------------------------------------------------
    // length and threshold
    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ctrl_r <= vbm_pkg::CTRL_RESET;
            sync_len_r <= vbm_pkg::SYNC_LEN_RESET;
            sync_thr_r <= vbm_pkg::SYNC_THR_RESET;
            period_stage_r <= vbm_pkg::PERIOD_RESET;
        end else if (host_wr) begin
            unique case (host_addr)
                vbm_pkg::ADDR_CTRL: ctrl_r <= host_wdata;
                vbm_pkg::ADDR_SYNC_LEN: sync_len_r <= host_wdata;
                vbm_pkg::ADDR_SYNC_THR: sync_thr_r <= host_wdata;
                vbm_pkg::ADDR_PERIOD_LO: period_stage_r[7:0] <= host_wdata;
                vbm_pkg::ADDR_PERIOD_MID: period_stage_r[15:8] <= host_wdata;
                vbm_pkg::ADDR_PERIOD_HI: period_stage_r[23:16] <= host_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            period_active_r <= vbm_pkg::PERIOD_RESET;
            arm_r <= 1'b0;
        end else begin
            arm_r <= host_wr_arm;
            if (host_wr_arm) begin
                period_active_r <= period_stage_r;
            end
        end
    end

    // ------------------------------------------------------------
    // host register reads
    // ------------------------------------------------------------
    // read has no side effect
    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            host_rdata <= 8'h0;
        end else if (host_rd) begin
            unique case (host_addr)
                vbm_pkg::ADDR_CTRL: host_rdata <= ctrl_r;
                vbm_pkg::ADDR_SYNC_LEN: host_rdata <= sync_len_r;
                vbm_pkg::ADDR_SYNC_THR: host_rdata <= sync_thr_r;
                vbm_pkg::ADDR_PERIOD_LO: host_rdata <= period_stage_r[7:0];
                vbm_pkg::ADDR_PERIOD_MID: host_rdata <= period_stage_r[15:8];
                vbm_pkg::ADDR_PERIOD_HI: host_rdata <= period_stage_r[23:16];
                vbm_pkg::ADDR_BER_LO: host_rdata <= ber_result[7:0];
                vbm_pkg::ADDR_BER_HI: host_rdata <= ber_result[15:8];
                vbm_pkg::ADDR_STATUS: host_rdata <= {3'h0, error_window_done,
                    sync_state_r, sync_lost_flag, in_sync_flag};
                default: host_rdata <= 8'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // encoder and decoder resets
    // ------------------------------------------------------------
    // pin or bit, same path
    vbm_reset_edge u_enc_rst (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_r),
        .pin_level(pin_sync_r[4]),
        .ctrl_bit(ctrl_r[vbm_pkg::CTRL_ENC_RST]),
        .reset_pulse(enc_pulse)
    );

    vbm_reset_edge u_dec_rst (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_r),
        .pin_level(pin_sync_r[5]),
        .ctrl_bit(ctrl_r[vbm_pkg::CTRL_DEC_RST]),
        .reset_pulse(dec_pulse)
    );

    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            encoder_reset <= 1'b0;
            decoder_reset <= 1'b0;
        end else begin
            encoder_reset <= enc_pulse;
            decoder_reset <= dec_pulse;
        end
    end

    // ------------------------------------------------------------
    // normalization rate test
    // ------------------------------------------------------------
    // free running test
    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            unit_cnt_r <= 6'h0;
            len_cnt_r <= 8'h0;
            norm_cnt_r <= 8'h0;
        end else if (dec_pulse || test_end) begin
            unit_cnt_r <= 6'h0;
            len_cnt_r <= 8'h0;
            norm_cnt_r <= 8'h0;
        end else begin
            norm_cnt_r <= norm_total;
            if (word_tick) begin
                unit_cnt_r <= unit_end ? 6'h0 : unit_cnt_r + 6'h1;
                if (unit_end) begin
                    len_cnt_r <= len_cnt_r + 8'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            in_sync_flag <= 1'b0;
            sync_lost_flag <= 1'b0;
        end else if (dec_pulse) begin
            in_sync_flag <= 1'b0;
            sync_lost_flag <= 1'b0;
        end else if (test_end) begin
            in_sync_flag <= (norm_total <= sync_thr_r);
            sync_lost_flag <= (norm_total > sync_thr_r);
        end
    end

    // ------------------------------------------------------------
    // sync offset state
    // ------------------------------------------------------------
    assign last_state = ctrl_r[vbm_pkg::CTRL_NSTATE_LO +: 2];

    always_comb begin
        sync_state_nxt = vbm_pkg::SS_ZERO;
        if (sync_state_r != vbm_pkg::vbm_sync_state_t'(last_state)) begin
            unique case (sync_state_r)
                vbm_pkg::SS_ZERO: sync_state_nxt = vbm_pkg::SS_ONE;
                vbm_pkg::SS_ONE: sync_state_nxt = vbm_pkg::SS_TWO;
                vbm_pkg::SS_TWO: sync_state_nxt = vbm_pkg::SS_THREE;
                vbm_pkg::SS_THREE: sync_state_nxt = vbm_pkg::SS_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sync_state_r <= vbm_pkg::SS_ZERO;
        end else if (dec_pulse) begin
            sync_state_r <= vbm_pkg::SS_ZERO;
        end else if (step_rise) begin
            sync_state_r <= sync_state_nxt;
        end
    end

    // ------------------------------------------------------------
    // input format conversion to offset binary
    // ------------------------------------------------------------
    // format select
    function automatic logic [2:0] to_offbin(input logic [2:0] w, input logic ob);
        logic [2:0] r;
        r = w;
        if (!ob) begin
            r = w[2] ? {1'b0, ~w[1:0]} : {1'b1, w[1:0]};
        end
        return r;
    endfunction

    assign c0 = to_offbin(word_sync_r[2:0], ctrl_r[vbm_pkg::CTRL_FMT_OFFBIN]);
    assign c1 = to_offbin(word_sync_r[5:3], ctrl_r[vbm_pkg::CTRL_FMT_OFFBIN]);
    assign c2 = to_offbin(word_sync_r[8:6], ctrl_r[vbm_pkg::CTRL_FMT_OFFBIN]);

    // ------------------------------------------------------------
    // offset applied just before the decoder
    // ------------------------------------------------------------
    // symbol history for timing re-alignment
    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            c0_d1_r <= 3'h0;
            c0_d2_r <= 3'h0;
            c0_d3_r <= 3'h0;
        end else if (word_tick) begin
            c0_d1_r <= c0;
            c0_d2_r <= c0_d1_r;
            c0_d3_r <= c0_d2_r;
        end
    end

    always_comb begin
        c0_sel = c0;
        unique case (sync_state_r)
            vbm_pkg::SS_ZERO: c0_sel = c0;
            vbm_pkg::SS_ONE: c0_sel = c0_d1_r;
            vbm_pkg::SS_TWO: c0_sel = c0_d2_r;
            vbm_pkg::SS_THREE: c0_sel = c0_d3_r;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            dec_word_0 <= 3'h0;
            dec_word_1 <= 3'h0;
            dec_word_2 <= 3'h0;
        end else if (word_tick) begin
            dec_word_2 <= c2;
            if (!ctrl_r[vbm_pkg::CTRL_PERMUTE]) begin
                dec_word_0 <= c0_sel;
                dec_word_1 <= c1;
            end else begin
                dec_word_0 <= sync_state_r[0] ? c1 : c0;
                dec_word_1 <= (sync_state_r[0] ? c0 : c1) ^ {3{sync_state_r[1]}};
            end
        end
    end

    // ------------------------------------------------------------
    // channel error rate monitor
    // ------------------------------------------------------------
    // counters
    vbm_ber_counter u_ber (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_r),
        .word_tick(word_tick),
        .mismatch(mismatch),
        .restart(arm_r),
        .period_value(period_active_r),
        .result(ber_result),
        .done(ber_done)
    );

    always_ff @(posedge sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            error_window_done <= 1'b0;
        end else begin
            error_window_done <= ber_done;
        end
    end
endmodule // vbm_monitor
`default_nettype wire

// ==== tb/vbm_monitor_chk.sv ====
// port assertions for the sync and error rate monitor
`timescale 1ns/10ps
`default_nettype none
module vbm_monitor_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic host_rd,
    input wire logic [7:0] host_rdata,
    input wire logic decoder_reset_pin,
    input wire logic in_sync_flag,
    input wire logic sync_lost_flag,
    input wire logic error_window_done,
    input wire logic encoder_reset,
    input wire logic decoder_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_flags; !(in_sync_flag && sync_lost_flag); endproperty
    a_flags: assert property (p_flags) else $error("both sync flags high");
    property p_enc_pw; $rose(encoder_reset) |=> encoder_reset ##1 !encoder_reset; endproperty
    a_enc_pw: assert property (p_enc_pw) else $error("encoder pulse width");
    property p_dec_pw; $rose(decoder_reset) |=> decoder_reset ##1 !decoder_reset; endproperty
    a_dec_pw: assert property (p_dec_pw) else $error("decoder pulse width");
    property p_dec_pin; $rose(decoder_reset_pin) |-> ##[1:6] decoder_reset; endproperty
    a_dec_pin: assert property (p_dec_pin) else $error("pin gave no reset");
    property p_dec_clr; $fell(decoder_reset) |-> !in_sync_flag && !sync_lost_flag; endproperty
    a_dec_clr: assert property (p_dec_clr) else $error("flags kept over reset");
    property p_done_min; $rose(error_window_done) |=> error_window_done [*4]; endproperty
    a_done_min: assert property (p_done_min) else $error("done too short");
    property p_done_max; $rose(error_window_done) |-> ##[1:12] !error_window_done; endproperty
    a_done_max: assert property (p_done_max) else $error("done too long");
    property p_rd_hold; !host_rd |=> $stable(host_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    c_lost: cover property ($rose(sync_lost_flag));
    c_insync: cover property ($rose(in_sync_flag));
    c_done: cover property ($rose(error_window_done));
endmodule // vbm_monitor_chk
bind vbm_monitor vbm_monitor_chk u_chk (.sys_clk, .rst_n, .host_rd, .host_rdata,
    .decoder_reset_pin, .in_sync_flag, .sync_lost_flag, .error_window_done,
    .encoder_reset, .decoder_reset);
`default_nettype wire

// ==== tb/vbm_demod_model.sv ====
// demodulator and decoder side model: words, ticks, events
`timescale 1ns/10ps
`default_nettype none
module vbm_demod_model (
    input wire logic sys_clk,
    input wire logic norm_fast,
    input wire logic err_on,
    input wire logic hard,
    output logic word_clk,
    output logic norm_ev,
    output logic mis,
    output logic [2:0] cw
);
    logic [1:0] div_r = 2'h0;
    always @(posedge sys_clk) begin
        div_r <= div_r + 2'h1;
    end
    // one word tick per four cycles
    assign word_clk = div_r[1];
    assign norm_ev = norm_fast & div_r[1];
    assign mis = err_on;
    assign cw = {hard, 2'b01};
endmodule // vbm_demod_model
`default_nettype wire

// ==== tb/vbm_monitor_tb.sv ====
// self-checking bench for the sync and error rate monitor
`timescale 1ns/10ps
`default_nettype none
module vbm_monitor_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, rd_v;
    logic [2:0] code_word_in_0, code_word_in_1, code_word_in_2;
    logic [2:0] dec_word_0, dec_word_1, dec_word_2;
    logic decoder_output_clock, normalization_event, reencode_mismatch;
    logic sync_step_request = 1'b0, encoder_reset_pin = 1'b0, decoder_reset_pin = 1'b0;
    logic in_sync_flag, sync_lost_flag, error_window_done, encoder_reset, decoder_reset;
    logic norm_fast = 1'b0, err_on = 1'b0, hard = 1'b1;
    int n_errors = 0, checks = 0;
    always #5 sys_clk = ~sys_clk;
    assign code_word_in_1 = code_word_in_0;
    assign code_word_in_2 = code_word_in_0;
    vbm_monitor u_dut (.sys_clk, .rst_n, .host_addr, .host_wr, .host_rd, .host_wdata,
        .host_rdata, .code_word_in_0, .code_word_in_1, .code_word_in_2,
        .decoder_output_clock, .normalization_event, .reencode_mismatch,
        .sync_step_request, .encoder_reset_pin, .decoder_reset_pin, .dec_word_0,
        .dec_word_1, .dec_word_2, .in_sync_flag, .sync_lost_flag, .error_window_done,
        .encoder_reset, .decoder_reset);
    vbm_demod_model u_dem (.sys_clk, .norm_fast, .err_on, .hard,
        .word_clk(decoder_output_clock), .norm_ev(normalization_event),
        .mis(reencode_mismatch), .cw(code_word_in_0));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge sys_clk);
        host_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge sys_clk);
        host_rd <= 1'b0;
        cyc(1);
        rd_v = host_rdata;
    endtask
    task automatic wdone();
        for (int i = 0; i < 6000 && !error_window_done; i++) begin
            cyc(1);
        end
        cmp(error_window_done, 8'h01);
        cyc(6);
        cmp(error_window_done, 8'h01);
        cyc(2);
        cmp(error_window_done, 8'h00);
        cyc(12);
    endtask
    task automatic t_format();
        wr(8'h14, 8'h00);
        cyc(20);
        cmp(dec_word_1, 8'h02);
        cmp(dec_word_0, 8'h02);
        cmp(dec_word_2, 8'h02);
        wr(8'h14, 8'h01);
        cyc(20);
        cmp(dec_word_1, 8'h05);
    endtask
    task automatic t_sync();
        wr(8'h14, 8'h39);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h02);
        decoder_reset_pin <= 1'b1;
        cyc(30);
        @(posedge sys_clk);
        decoder_reset_pin <= 1'b0;
        norm_fast <= 1'b1;
        cyc(700);
        cmp({in_sync_flag, sync_lost_flag}, 8'h01);
        for (int i = 1; i < 6; i++) begin
            @(posedge sys_clk);
            sync_step_request <= 1'b1;
            cyc(4);
            @(posedge sys_clk);
            sync_step_request <= 1'b0;
            cyc(10);
            rd(8'h1b);
            cmp(rd_v[3:2], 8'(i % 4));
            cmp(dec_word_1, (i % 4 > 1) ? 8'h02 : 8'h05);
        end
        @(posedge sys_clk);
        norm_fast <= 1'b0;
        cyc(700);
        cmp({in_sync_flag, sync_lost_flag}, 8'h02);
        wr(8'h14, 8'h3d);
        wr(8'h14, 8'h39);
        cyc(5);
        rd(8'h1b);
        cmp(rd_v[3:0], 8'h00);
        @(posedge sys_clk);
        encoder_reset_pin <= 1'b1;
        cyc(4);
        cmp(encoder_reset, 8'h01);
        cyc(2);
        cmp(encoder_reset, 8'h00);
    endtask
    task automatic t_ber();
        wr(8'h10, 8'hff);
        wr(8'h11, 8'hff);
        wr(8'h12, 8'hff);
        wr(8'h18, 8'h5a);
        wdone();
        rd(8'h19);
        cmp(rd_v, 8'h01);
        rd(8'h1a);
        cmp(rd_v, 8'h00);
        @(posedge sys_clk);
        err_on <= 1'b1;
        wdone();
        wdone();
        rd(8'h19);
        cmp(rd_v, 8'h7e);
    endtask
    task automatic end_sim();
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // main sequence after 20 reset cycles
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(5);
        t_format();
        t_sync();
        t_ber();
        end_sim();
    end
    // watchdog
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
endmodule // vbm_monitor_tb
`default_nettype wire
